// ### verilog/isg_pkg.sv
// constants shared by the isolated spi and gp channel block
package isg_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   // wake-up latency after chip select falls, a least time
   localparam int WAKE_NS = 100;
   localparam int WAKE_CYC_RAW = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
   // peak sampling jitter of the gp channels, a longest time
   localparam int GP_JITTER_NS = 10000;
   localparam int GP_FRAME_RAW = GP_JITTER_NS / CLK_PERIOD_NS;
   localparam int GP_FRAME_CYC = (GP_FRAME_RAW < 1) ? 1 : GP_FRAME_RAW;
   // cycles spent sampling per round trip, one per direction
   localparam int GP_SAMPLE_CYC = 2;

   // ****************************************
   // channel counts
   // ****************************************
   localparam int GP_N_FWD = 2;
   localparam int GP_N_REV = 1;

   // ****************************************
   // synchroniser vector layout
   // ****************************************
   localparam int SY_CLK = 0;
   localparam int SY_MOSI = 1;
   localparam int SY_CS = 2;
   localparam int SY_MISO = 3;
   localparam int SY_HPWR = 4;
   localparam int SY_FPWR = 5;
   localparam int SY_GP = 6;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic RST_CS = 1'h1;
   localparam logic RST_LOW = 1'h0;

   // ****************************************
   // gp packet sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      GP_SAMPLE_FWD = 2'b00,
      GP_SHIFT_FWD = 2'b01,
      GP_SAMPLE_REV = 2'b10,
      GP_SHIFT_REV = 2'b11
   } isg_gp_state_t;

endpackage : isg_pkg

// ### verilog/isg_isolated_spi_gpio.sv
// isolated spi pass-through channels and sampled gp channels
//
// Contract
// - carry clock, data, select across; data back
// - no clock sync; any spi mode passes
// - select low active; high means low power
// - wake gated channels about 100 ns after fall
// - select high: far select high, others tristate
// - select low: outputs follow their inputs
// - sample side together, one packet, alternate directions
// - gp outputs lag inputs up to 10 us; the code lags up to about 16.5 us host to far, 13.3 us far to host
// - gp outputs low until both sides powered
// - power loss: survivor holds, losing side low
`timescale 1ns/1ps

module isg_isolated_spi_gpio
   import isg_pkg::*;
#(
   parameter int N_FWD = GP_N_FWD,
   parameter int N_REV = GP_N_REV,
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int FRAME_CYCLES = GP_FRAME_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // host side spi pins
   input wire logic host_clock_in,
   input wire logic host_data_in_fwd,
   input wire logic host_chip_sel_in,
   output logic host_data_out_back,
   output logic host_data_out_back_oe,
   // far side spi pins
   output logic far_clock_out,
   output logic far_clock_out_oe,
   output logic far_data_out_fwd,
   output logic far_data_out_fwd_oe,
   output logic far_chip_sel_out,
   input wire logic far_data_in_back,
   // supply presence levels
   input wire logic host_supply,
   input wire logic far_supply,
   // gp channels, host to far
   input wire logic [N_FWD-1:0] gp_input_line_host,
   output logic [N_FWD-1:0] far_gp_output,
   // gp channels, far to host
   input wire logic [N_REV-1:0] gp_input_line_far,
   output logic [N_REV-1:0] host_gp_output
);

   // ****************************************
   // derived sizes
   // ****************************************
   localparam int N_ALL = N_FWD + N_REV;
   localparam int SY_W = SY_GP + N_ALL;
   localparam int BIT_RAW = (FRAME_CYCLES - GP_SAMPLE_CYC) / N_ALL;
   localparam int BIT_CYC = (BIT_RAW < 1) ? 1 : BIT_RAW;
   localparam int CW = $clog2(BIT_CYC + 1);
   localparam int NMAX = (N_FWD > N_REV) ? N_FWD : N_REV;
   localparam int IW = (NMAX > 1) ? $clog2(NMAX) : 1;
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
   localparam logic [IW-1:0] FWD_LAST = IW'(N_FWD - 1);
   localparam logic [IW-1:0] REV_LAST = IW'(N_REV - 1);
   localparam logic [WW-1:0] WAKE_DONE = WW'(WAKE_CYCLES);

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [SY_W-1:0] async_in;
   logic [SY_W-1:0] sync_a;
   logic [SY_W-1:0] sync_b;

   assign async_in = {gp_input_line_far, gp_input_line_host,
                      far_supply, host_supply, far_data_in_back,
                      host_chip_sel_in, host_data_in_fwd, host_clock_in};

   // every pin is treated alike, so no channel is aligned to the clock
   genvar gi;
   generate
      for (gi = 0; gi < SY_W; gi = gi + 1) begin : g_sync
         always_ff @(posedge clk) begin
            if (!resetn) begin
               sync_a[gi] <= (gi == SY_CS) ? RST_CS : RST_LOW;
               sync_b[gi] <= (gi == SY_CS) ? RST_CS : RST_LOW;
            end else begin
               sync_a[gi] <= async_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   logic s_clk;
   logic s_mosi;
   logic s_cs;
   logic s_miso;
   logic s_hpwr;
   logic s_fpwr;
   logic [N_FWD-1:0] s_gp_host;
   logic [N_REV-1:0] s_gp_far;

   assign s_clk = sync_b[SY_CLK];
   assign s_mosi = sync_b[SY_MOSI];
   assign s_cs = sync_b[SY_CS];
   assign s_miso = sync_b[SY_MISO];
   assign s_hpwr = sync_b[SY_HPWR];
   assign s_fpwr = sync_b[SY_FPWR];
   assign s_gp_host = sync_b[SY_GP +: N_FWD];
   assign s_gp_far = sync_b[SY_GP + N_FWD +: N_REV];

   // ****************************************
   // chip select gating and wake-up
   // ****************************************
   logic [WW-1:0] wake_cnt;
   logic spi_active;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_cnt <= '0;
      end else if (s_cs) begin
         wake_cnt <= '0;
      end else if (wake_cnt != WAKE_DONE) begin
         wake_cnt <= wake_cnt + WW'(1);
      end
   end

   // rising select cuts the channels at once, no wait
   assign spi_active = !s_cs && (wake_cnt == WAKE_DONE);

   // ****************************************
   // spi pass-through outputs
   // ****************************************
   // far select mirrors host select
   // low select drives far select low
   always_ff @(posedge clk) begin
      if (!resetn) begin
         far_chip_sel_out <= RST_CS;
      end else begin
         far_chip_sel_out <= s_cs;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         far_clock_out_oe <= RST_LOW;
         far_data_out_fwd_oe <= RST_LOW;
         host_data_out_back_oe <= RST_LOW;
      end else begin
         far_clock_out_oe <= spi_active;
         far_data_out_fwd_oe <= spi_active;
         host_data_out_back_oe <= spi_active;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         far_clock_out <= RST_LOW;
         far_data_out_fwd <= RST_LOW;
         host_data_out_back <= RST_LOW;
      end else begin
         // parked levels held low to save toggling power
         far_clock_out <= spi_active ? s_clk : RST_LOW;
         far_data_out_fwd <= spi_active ? s_mosi : RST_LOW;
         host_data_out_back <= spi_active ? s_miso : RST_LOW;
      end
   end

   // ****************************************
   // gp packet sequencer
   // ****************************************
   isg_gp_state_t gp_state;
   logic [CW-1:0] bit_cnt;
   logic [IW-1:0] bit_idx;
   logic bit_end;
   logic [N_FWD-1:0] fwd_tx;
   logic [N_REV-1:0] rev_tx;
   logic [N_FWD-1:0] fwd_rx;
   logic [N_REV-1:0] rev_rx;
   logic coil_bit;
   logic fwd_done;
   logic rev_done;

   assign bit_end = (bit_cnt == BIT_LAST);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         gp_state <= GP_SAMPLE_FWD;
         bit_cnt <= '0;
         bit_idx <= '0;
      end else begin
         case (gp_state)
            GP_SAMPLE_FWD: begin
               bit_cnt <= '0;
               bit_idx <= '0;
               gp_state <= GP_SHIFT_FWD;
            end
            GP_SHIFT_FWD: begin
               if (bit_end) begin
                  bit_cnt <= '0;
                  if (bit_idx == FWD_LAST) begin
                     bit_idx <= '0;
                     gp_state <= GP_SAMPLE_REV;
                  end else begin
                     bit_idx <= bit_idx + IW'(1);
                  end
               end else begin
                  bit_cnt <= bit_cnt + CW'(1);
               end
            end
            GP_SAMPLE_REV: begin
               bit_cnt <= '0;
               bit_idx <= '0;
               gp_state <= GP_SHIFT_REV;
            end
            GP_SHIFT_REV: begin
               if (bit_end) begin
                  bit_cnt <= '0;
                  if (bit_idx == REV_LAST) begin
                     bit_idx <= '0;
                     gp_state <= GP_SAMPLE_FWD;
                  end else begin
                     bit_idx <= bit_idx + IW'(1);
                  end
               end else begin
                  bit_cnt <= bit_cnt + CW'(1);
               end
            end
            default: begin
               gp_state <= GP_SAMPLE_FWD;
            end
         endcase
      end
   end

   // sample one side in one cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fwd_tx <= '0;
         rev_tx <= '0;
      end else begin
         if (gp_state == GP_SAMPLE_FWD) begin
            fwd_tx <= s_gp_host;
         end
         if (gp_state == GP_SAMPLE_REV) begin
            rev_tx <= s_gp_far;
         end
      end
   end

   // one bit at a time on the coil
   always_ff @(posedge clk) begin
      if (!resetn) begin
         coil_bit <= RST_LOW;
      end else if (gp_state == GP_SHIFT_FWD) begin
         coil_bit <= fwd_tx[bit_idx];
      end else if (gp_state == GP_SHIFT_REV) begin
         coil_bit <= rev_tx[bit_idx];
      end else begin
         coil_bit <= RST_LOW;
      end
   end

   // receiver samples at bit end, well after the coil settled
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fwd_rx <= '0;
         rev_rx <= '0;
         fwd_done <= RST_LOW;
         rev_done <= RST_LOW;
      end else begin
         fwd_done <= RST_LOW;
         rev_done <= RST_LOW;
         if (gp_state == GP_SHIFT_FWD && bit_end) begin
            fwd_rx[bit_idx] <= coil_bit;
            fwd_done <= (bit_idx == FWD_LAST);
         end
         if (gp_state == GP_SHIFT_REV && bit_end) begin
            rev_rx[bit_idx] <= coil_bit;
            rev_done <= (bit_idx == REV_LAST);
         end
      end
   end

   // ****************************************
   // gp supply handling
   // ****************************************
   logic both_pwr;
   logic ever_both;

   assign both_pwr = s_hpwr && s_fpwr;

   // remembers a completed startup; cleared only when both go down
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ever_both <= RST_LOW;
      end else if (both_pwr) begin
         ever_both <= 1'h1;
      end else if (!s_hpwr && !s_fpwr) begin
         ever_both <= RST_LOW;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         far_gp_output <= '0;
      end else if (!s_fpwr || !ever_both) begin
         far_gp_output <= '0;
      end else if (both_pwr && fwd_done) begin
         far_gp_output <= fwd_rx;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         host_gp_output <= '0;
      end else if (!s_hpwr || !ever_both) begin
         host_gp_output <= '0;
      end else if (both_pwr && rev_done) begin
         host_gp_output <= rev_rx;
      end
   end

endmodule : isg_isolated_spi_gpio

// ### dv/isg_properties.sv
// assertion checker for the isolated spi and gp block
`timescale 1ns/1ps
module isg_properties
   import isg_pkg::*;
#(
   parameter int N_FWD = GP_N_FWD,
   parameter int N_REV = GP_N_REV
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // spi pins
   input wire logic host_clock_in,
   input wire logic host_data_in_fwd,
   input wire logic host_chip_sel_in,
   input wire logic host_data_out_back,
   input wire logic host_data_out_back_oe,
   input wire logic far_clock_out,
   input wire logic far_clock_out_oe,
   input wire logic far_data_out_fwd,
   input wire logic far_data_out_fwd_oe,
   input wire logic far_chip_sel_out,
   input wire logic far_data_in_back,
   // gp and supplies
   input wire logic host_supply,
   input wire logic far_supply,
   input wire logic [N_FWD-1:0] far_gp_output,
   input wire logic [N_REV-1:0] host_gp_output
);
   // ****************************************
   // properties
   // ****************************************
   // sync flops hold reset values for a few edges
   logic [2:0] age;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         age <= 3'h0;
      end else if (age != 3'h7) begin
         age <= age + 3'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || age != 3'h7);
   property p_sel;
      far_chip_sel_out == $past(host_chip_sel_in, 3);
   endproperty
   a_sel: assert property (p_sel) else $error("select path");
   property p_clk;
      far_clock_out_oe |-> far_clock_out == $past(host_clock_in, 3);
   endproperty
   a_clk: assert property (p_clk) else $error("clock path");
   property p_fwd;
      far_data_out_fwd_oe |-> far_data_out_fwd == $past(host_data_in_fwd, 3);
   endproperty
   a_fwd: assert property (p_fwd) else $error("fwd path");
   property p_back;
      host_data_out_back_oe |->
         host_data_out_back == $past(far_data_in_back, 3);
   endproperty
   a_back: assert property (p_back) else $error("back path");
   property p_park;
      far_chip_sel_out |->
         !(far_clock_out_oe || far_data_out_fwd_oe || host_data_out_back_oe);
   endproperty
   a_park: assert property (p_park) else $error("not parked");
   property p_wake;
      $fell(far_chip_sel_out) |->
         !far_clock_out_oe ##1 (far_clock_out_oe || far_chip_sel_out);
   endproperty
   a_wake: assert property (p_wake) else $error("wake late");
   property p_host_low;
      (!host_supply) [*5] |-> host_gp_output == '0;
   endproperty
   a_host_low: assert property (p_host_low) else $error("host gp");
   property p_far_low;
      (!far_supply) [*5] |-> far_gp_output == '0;
   endproperty
   a_far_low: assert property (p_far_low) else $error("far gp");
   property p_far_hold;
      (far_supply && !host_supply) [*5] |-> $stable(far_gp_output);
   endproperty
   a_far_hold: assert property (p_far_hold) else $error("no hold");
   c_xfer: cover property (far_clock_out_oe && $changed(far_clock_out));
   c_gp: cover property ($changed(far_gp_output));
   c_hold: cover property (!host_supply && far_gp_output != '0);
endmodule : isg_properties

bind isg_isolated_spi_gpio isg_properties #(
   .N_FWD(N_FWD),
   .N_REV(N_REV)
) i_props (
   .clk(clk),
   .resetn(resetn),
   .host_clock_in(host_clock_in),
   .host_data_in_fwd(host_data_in_fwd),
   .host_chip_sel_in(host_chip_sel_in),
   .host_data_out_back(host_data_out_back),
   .host_data_out_back_oe(host_data_out_back_oe),
   .far_clock_out(far_clock_out),
   .far_clock_out_oe(far_clock_out_oe),
   .far_data_out_fwd(far_data_out_fwd),
   .far_data_out_fwd_oe(far_data_out_fwd_oe),
   .far_chip_sel_out(far_chip_sel_out),
   .far_data_in_back(far_data_in_back),
   .host_supply(host_supply),
   .far_supply(far_supply),
   .far_gp_output(far_gp_output),
   .host_gp_output(host_gp_output)
);

// ### dv/isg_far_peripheral.sv
// far side spi peripheral model echoing inverted data
`timescale 1ns/1ps
module isg_far_peripheral (
   // clock and far pins
   input wire logic clk,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sel_n,
   output logic sdo
);
   logic sck_q;
   initial sck_q = 1'b0;
   initial sdo = 1'b0;
   // unselected line toggles so a stale level never looks valid
   always @(posedge clk) begin
      sck_q <= sck;
      if (sel_n) begin
         sdo <= ~sdo;
      end else if (sck != sck_q) begin
         sdo <= ~sdi;
      end
   end
endmodule : isg_far_peripheral

// ### dv/tb_top.sv
// self-checking bench for the isolated spi and gp block
`timescale 1ns/1ps
module tb_top;
   import isg_pkg::*;
   localparam int FRAME = 20;
   // two frames plus sync margin
   localparam int GP_WAIT = 2 * FRAME + 5;
   logic clk, resetn, host_clock_in, host_data_in_fwd, host_chip_sel_in;
   logic far_data_in_back, host_supply, far_supply;
   logic host_data_out_back, host_data_out_back_oe, far_clock_out;
   logic far_clock_out_oe, far_data_out_fwd, far_data_out_fwd_oe;
   logic far_chip_sel_out;
   logic [1:0] gp_input_line_host, far_gp_output;
   logic [0:0] gp_input_line_far, host_gp_output;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   // pull-downs on the tristated lines
   wire sck_w = far_clock_out_oe ? far_clock_out : 1'b0;
   wire sdi_w = far_data_out_fwd_oe ? far_data_out_fwd : 1'b0;
   wire back_w = host_data_out_back_oe ? host_data_out_back : 1'b0;

   isg_isolated_spi_gpio #(.FRAME_CYCLES(FRAME)) i_dut (
      .clk(clk),
      .resetn(resetn),
      .host_clock_in(host_clock_in),
      .host_data_in_fwd(host_data_in_fwd),
      .host_chip_sel_in(host_chip_sel_in),
      .host_data_out_back(host_data_out_back),
      .host_data_out_back_oe(host_data_out_back_oe),
      .far_clock_out(far_clock_out),
      .far_clock_out_oe(far_clock_out_oe),
      .far_data_out_fwd(far_data_out_fwd),
      .far_data_out_fwd_oe(far_data_out_fwd_oe),
      .far_chip_sel_out(far_chip_sel_out),
      .far_data_in_back(far_data_in_back),
      .host_supply(host_supply),
      .far_supply(far_supply),
      .gp_input_line_host(gp_input_line_host),
      .far_gp_output(far_gp_output),
      .gp_input_line_far(gp_input_line_far),
      .host_gp_output(host_gp_output)
   );
   isg_far_peripheral i_far (
      .clk(clk),
      .sck(sck_w),
      .sdi(sdi_w),
      .sel_n(far_chip_sel_out),
      .sdo(far_data_in_back)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic conclude();
      if (fail_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic t_xfer(input logic cpol);
      logic [7:0] tx;
      tx = 8'hA5 ^ {8{cpol}};
      host_clock_in <= cpol;
      tick(2);
      host_chip_sel_in <= 1'b0;
      tick(6);
      chk({5'h0, far_clock_out_oe, far_chip_sel_out, sck_w},
          {5'h0, 2'h2, cpol});
      for (int i = 7; i >= 0; i--) begin
         host_data_in_fwd <= tx[i];
         tick(4);
         host_clock_in <= ~cpol;
         tick(4);
         host_clock_in <= cpol;
         chk({6'h0, sck_w, sdi_w}, {6'h0, ~cpol, tx[i]});
         tick(4);
         // invert inside the concatenation, so the inversion stays one bit wide
         chk({7'h0, back_w}, {7'h0, ~tx[i]});
      end
      host_chip_sel_in <= 1'b1;
      tick(4);
      chk({4'h0, far_clock_out_oe, far_data_out_fwd_oe, host_data_out_back_oe,
           far_chip_sel_out}, 8'h1);
   endtask : t_xfer

   task automatic t_gp_power();
      gp_input_line_host <= 2'h3;
      gp_input_line_far <= 1'h1;
      host_supply <= 1'b1;
      tick(GP_WAIT);
      chk({5'h0, far_gp_output, host_gp_output}, 8'h0);
      far_supply <= 1'b1;
      for (int v = 0; v < 4; v++) begin
         gp_input_line_host <= v[1:0];
         gp_input_line_far <= ~v[0:0];
         tick(GP_WAIT);
         chk({5'h0, far_gp_output, host_gp_output},
             {5'h0, v[1:0], ~v[0]});
      end
   endtask : t_gp_power

   task automatic t_gp_loss();
      gp_input_line_far <= 1'h1;
      tick(GP_WAIT);
      far_supply <= 1'b0;
      gp_input_line_far <= 1'h0;
      gp_input_line_host <= 2'h0;
      tick(GP_WAIT);
      chk({5'h0, far_gp_output, host_gp_output}, 8'h1);
      gp_input_line_host <= 2'h2;
      far_supply <= 1'b1;
      tick(GP_WAIT);
      host_supply <= 1'b0;
      gp_input_line_host <= 2'h1;
      gp_input_line_far <= 1'h1;
      tick(GP_WAIT);
      chk({5'h0, far_gp_output, host_gp_output}, 8'h4);
   endtask : t_gp_loss

   initial begin
      resetn = 1'b0;
      host_clock_in = 1'b0;
      host_data_in_fwd = 1'b0;
      host_chip_sel_in = 1'b1;
      host_supply = 1'b0;
      far_supply = 1'b0;
      gp_input_line_host = 2'h0;
      gp_input_line_far = 1'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      tick(6);
      chk({4'h0, far_clock_out_oe, far_data_out_fwd_oe, host_data_out_back_oe,
           far_chip_sel_out}, 8'h1);
      t_xfer(1'b0);
      t_xfer(1'b1);
      t_gp_power();
      t_gp_loss();
      conclude();
   end
endmodule : tb_top
